// [src/clamp_timing_pkg.sv]
// Package for the clamp timing generator: register map, reset values, field positions,
// state codes and the bus request carrier.
// Assumes a single 125 MHz clock, each cycle being one pixel clock.
package clamp_timing_pkg;

    // Clock
    localparam int unsigned CLK_PERIOD_NS = 8;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET      = 8'h00;
    localparam logic [7:0] PLACEMENT_OFFSET = 8'h04;
    localparam logic [7:0] DURATION_OFFSET  = 8'h08;
    localparam logic [7:0] STATUS_OFFSET    = 8'h0c;
    localparam logic [7:0] TRIM_OFFSET      = 8'h10;

    // Control fields
    localparam int unsigned CTRL_EXT_SEL_BIT  = 0;
    localparam int unsigned CTRL_POLARITY_BIT = 1;

    // Status fields
    localparam int unsigned STATUS_CLAMP_BIT = 0;
    localparam int unsigned STATUS_PLACE_BIT = 1;

    // Trim register: one byte lane per channel, low 7 bits used
    localparam int unsigned TRIM_LANE_WIDTH = 8;
    localparam int unsigned NUM_CHANNELS    = 3;

    // Reset values
    localparam logic       EXT_SEL_RESET   = 1'b0;
    localparam logic       POLARITY_RESET  = 1'b1;
    localparam logic [7:0] PLACEMENT_RESET = 8'h08;
    localparam logic [7:0] DURATION_RESET  = 8'h14;

    // Offset trim range, two's complement, +-63 steps
    localparam logic [6:0] TRIM_RESET = 7'h3f;
    localparam logic [6:0] TRIM_MIN   = 7'h41;
    localparam logic [6:0] TRIM_STEP  = 7'h01;
    localparam logic [7:0] BLACK_CODE = 8'h00;

    // Clamp window state machine, one-hot
    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b001,
        ST_PLACE = 3'b010,
        ST_CLAMP = 3'b100
    } clamp_state_e;

    // Latched AHB address phase
    typedef struct packed
    {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } ahb_req_s;

endpackage : clamp_timing_pkg

// [src/clamp_offset_trim.sv]
// One channel of black-level offset trim.
// Assumes the window and the converter code are synchronous to the clock.
module clamp_offset_trim
    import clamp_timing_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       rstn_in,
    // Control
    input  wire logic       window_in,
    input  wire logic [7:0] code_in,
    input  wire logic       load_in,
    input  wire logic [6:0] load_val_in,
    // Trim value
    output logic      [6:0] offset_out
);

    logic [6:0] offset_reg;
    logic [6:0] offset_next;

    // Down-only trim: starts high and steps down until black or the TRIM_MIN floor
    always_comb
    begin
        offset_next = offset_reg;
        if (load_in)
        begin
            offset_next = load_val_in;
        end
        else if (window_in && code_in != BLACK_CODE && offset_reg != TRIM_MIN)
        begin
            offset_next = offset_reg - TRIM_STEP;
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            offset_reg <= TRIM_RESET;
        end
        else
        begin
            offset_reg <= offset_next;
        end
    end

    assign offset_out = offset_reg;

    property p_trim_step;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (window_in && !load_in && code_in != BLACK_CODE && offset_reg != TRIM_MIN)
            |=> (offset_reg == $past(offset_reg) - TRIM_STEP);
    endproperty
    a_trim_step: assert property (p_trim_step) else $error("Trim did not step toward black");

    property p_trim_hold;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (!load_in && (!window_in || code_in == BLACK_CODE)) |=> $stable(offset_reg);
    endproperty
    a_trim_hold: assert property (p_trim_hold) else $error("Trim moved outside clamp need");

endmodule : clamp_offset_trim

// [src/clamp_timing_gen.sv]
// Clamp window generator with AHB-Lite register slave and three channel offset trims.
// Assumes core_clk_in is the pixel clock and hsync_in is active high and synchronous.
//
// The AHB-Lite slave port and the register offsets were decided locally.

// Functional notes
// - Wait placement count after hsync trailing edge
// - Hold clamp for duration count, then end
// - External select uses external strobe for window
// - Polarity bit sets external strobe active level
// - Trim offset so black reads zero
// - External select resets to 0, strobe ignored
module clamp_timing_gen
    import clamp_timing_pkg::*;
(
    // Clock and reset
    input  wire logic                    core_clk_in,
    input  wire logic                    rstn_in,
    // AHB-Lite slave
    input  wire logic                    hsel_in,
    input  wire logic [31:0]             haddr_in,
    input  wire logic [1:0]              htrans_in,
    input  wire logic                    hwrite_in,
    input  wire logic [2:0]              hsize_in,
    input  wire logic [31:0]             hwdata_in,
    input  wire logic                    hready_in,
    output logic      [31:0]             hrdata_out,
    output logic                         hreadyout_out,
    output logic                         hresp_out,
    // Video timing
    input  wire logic                    hsync_in,
    input  wire logic                    clamp_strobe_in,
    // Converter codes and trims
    input  wire logic [NUM_CHANNELS-1:0][7:0] code_in,
    output logic      [NUM_CHANNELS-1:0][6:0] offset_out,
    output logic                         clamp_active_out
);

    // Register state
    logic         ext_sel_reg;
    logic         ext_sel_next;
    logic         polarity_reg;
    logic         polarity_next;
    logic [7:0]   placement_reg;
    logic [7:0]   placement_next;
    logic [7:0]   duration_reg;
    logic [7:0]   duration_next;
    ahb_req_s     req_reg;
    ahb_req_s     req_next;
    logic [31:0]  rdata_reg;
    logic [31:0]  rdata_next;
    logic         trim_load;
    logic [NUM_CHANNELS-1:0][6:0] trim_val;

    // Timing state
    clamp_state_e state_reg;
    clamp_state_e state_next;
    logic [7:0]   cnt_reg;
    logic [7:0]   cnt_next;
    logic         hsync_prev_reg;
    logic         clamp_reg;
    logic         clamp_next;
    logic         trail_edge;
    logic         strobe_active;

    // Bus address phase and read data
    always_comb
    begin
        req_next.valid = hsel_in && hready_in && htrans_in[1];
        req_next.write = hwrite_in;
        req_next.addr  = haddr_in[7:0];
        rdata_next     = 32'h0000_0000;
        if (req_next.valid && !hwrite_in)
        begin
            case (haddr_in[7:0])
                CTRL_OFFSET:
                begin
                    rdata_next[CTRL_EXT_SEL_BIT]  = ext_sel_reg;
                    rdata_next[CTRL_POLARITY_BIT] = polarity_reg;
                end
                PLACEMENT_OFFSET: rdata_next[7:0] = placement_reg;
                DURATION_OFFSET:  rdata_next[7:0] = duration_reg;
                STATUS_OFFSET:
                begin
                    rdata_next[STATUS_CLAMP_BIT] = clamp_reg;
                    rdata_next[STATUS_PLACE_BIT] = (state_reg == ST_PLACE);
                end
                TRIM_OFFSET:
                begin
                    for (int i = 0; i < NUM_CHANNELS; i++)
                    begin
                        rdata_next[i*TRIM_LANE_WIDTH +: 7] = offset_out[i];
                    end
                end
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Register writes in the data phase
    always_comb
    begin
        ext_sel_next   = ext_sel_reg;
        polarity_next  = polarity_reg;
        placement_next = placement_reg;
        duration_next  = duration_reg;
        trim_load      = 1'b0;
        for (int i = 0; i < NUM_CHANNELS; i++)
        begin
            trim_val[i] = hwdata_in[i*TRIM_LANE_WIDTH +: 7];
        end
        if (req_reg.valid && req_reg.write)
        begin
            case (req_reg.addr)
                CTRL_OFFSET:
                begin
                    ext_sel_next  = hwdata_in[CTRL_EXT_SEL_BIT];
                    polarity_next = hwdata_in[CTRL_POLARITY_BIT];
                end
                PLACEMENT_OFFSET: placement_next = hwdata_in[7:0];
                DURATION_OFFSET:  duration_next  = hwdata_in[7:0];
                TRIM_OFFSET:      trim_load      = 1'b1;
                default:          trim_load      = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ext_sel_reg   <= EXT_SEL_RESET;
            polarity_reg  <= POLARITY_RESET;
            placement_reg <= PLACEMENT_RESET;
            duration_reg  <= DURATION_RESET;
            req_reg       <= '0;
            rdata_reg     <= 32'h0000_0000;
        end
        else
        begin
            ext_sel_reg   <= ext_sel_next;
            polarity_reg  <= polarity_next;
            placement_reg <= placement_next;
            duration_reg  <= duration_next;
            req_reg       <= req_next;
            rdata_reg     <= rdata_next;
        end
    end

    // Zero wait states; every access is OKAY, unmapped reads return zero
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign hrdata_out    = rdata_reg;

    // Internal window sequencer
    assign trail_edge    = hsync_prev_reg && !hsync_in;
    assign strobe_active = (clamp_strobe_in == polarity_reg);

    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        if (trail_edge)
        begin
            state_next = ST_PLACE;
            cnt_next   = placement_reg;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    cnt_next = 8'h00;
                end
                ST_PLACE:
                begin
                    if (cnt_reg != 8'h00)
                    begin
                        cnt_next = cnt_reg - 8'h01;
                    end
                    else if (duration_reg == 8'h00)
                    begin
                        state_next = ST_IDLE;
                    end
                    else
                    begin
                        state_next = ST_CLAMP;
                        cnt_next   = duration_reg - 8'h01;
                    end
                end
                ST_CLAMP:
                begin
                    if (cnt_reg != 8'h00)
                    begin
                        cnt_next = cnt_reg - 8'h01;
                    end
                    else
                    begin
                        state_next = ST_IDLE;
                    end
                end
                default:
                begin
                    state_next = ST_IDLE;
                    cnt_next   = 8'h00;
                end
            endcase
        end
        // Strobe only steers the window when selected; ignored otherwise
        clamp_next = ext_sel_reg ? strobe_active : (state_next == ST_CLAMP);
    end

    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state_reg      <= ST_IDLE;
            cnt_reg        <= 8'h00;
            hsync_prev_reg <= 1'b0;
            clamp_reg      <= 1'b0;
        end
        else
        begin
            state_reg      <= state_next;
            cnt_reg        <= cnt_next;
            hsync_prev_reg <= hsync_in;
            clamp_reg      <= clamp_next;
        end
    end

    assign clamp_active_out = clamp_reg;

    // Per channel trim, gated by the registered window
    for (genvar ch = 0; ch < NUM_CHANNELS; ch++)
    begin : g_trim
        clamp_offset_trim u_trim
        (
            .core_clk_in (core_clk_in),
            .rstn_in     (rstn_in),
            .window_in   (clamp_reg),
            .code_in     (code_in[ch]),
            .load_in     (trim_load),
            .load_val_in (trim_val[ch]),
            .offset_out  (offset_out[ch])
        );
    end

    property p_place_load;
        @(posedge core_clk_in) disable iff (!rstn_in)
        trail_edge |=> (state_reg == ST_PLACE && cnt_reg == $past(placement_reg));
    endproperty
    a_place_load: assert property (p_place_load) else $error("Placement not loaded on trailing edge");

    property p_clamp_length;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (state_reg == ST_PLACE && cnt_reg == 8'h00 && duration_reg != 8'h00 && !trail_edge)
            |=> (state_reg == ST_CLAMP && cnt_reg == $past(duration_reg) - 8'h01);
    endproperty
    a_clamp_length: assert property (p_clamp_length) else $error("Clamp did not start with duration");

    property p_clamp_end;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (state_reg == ST_CLAMP && cnt_reg == 8'h00 && !trail_edge) |=> (state_reg == ST_IDLE);
    endproperty
    a_clamp_end: assert property (p_clamp_end) else $error("Clamp did not end after duration");

    property p_ext_active;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (ext_sel_reg && clamp_strobe_in == polarity_reg) |=> clamp_active_out;
    endproperty
    a_ext_active: assert property (p_ext_active) else $error("External strobe did not open clamp");

    property p_ext_polarity;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (ext_sel_reg && clamp_strobe_in != polarity_reg) |=> !clamp_active_out;
    endproperty
    a_ext_polarity: assert property (p_ext_polarity) else $error("Inactive strobe level opened clamp");

    property p_internal_only;
        @(posedge core_clk_in) disable iff (!rstn_in)
        !ext_sel_reg |=> (clamp_active_out == (state_reg == ST_CLAMP));
    endproperty
    a_internal_only: assert property (p_internal_only) else $error("Clamp not from internal timing");

    property p_restart;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (trail_edge && state_reg != ST_IDLE) |=> (state_reg == ST_PLACE && cnt_reg == $past(placement_reg));
    endproperty
    a_restart: assert property (p_restart) else $error("Trailing edge did not restart placement");

    property p_place_count;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (state_reg == ST_PLACE && cnt_reg != 8'h00 && !trail_edge)
            |=> (state_reg == ST_PLACE && cnt_reg == $past(cnt_reg) - 8'h01);
    endproperty
    a_place_count: assert property (p_place_count) else $error("Placement count did not step down");

    property p_clamp_count;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (state_reg == ST_CLAMP && cnt_reg != 8'h00 && !trail_edge)
            |=> (state_reg == ST_CLAMP && cnt_reg == $past(cnt_reg) - 8'h01);
    endproperty
    a_clamp_count: assert property (p_clamp_count) else $error("Clamp count did not step down");

    // Zero duration skips the window entirely
    property p_zero_duration;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (state_reg == ST_PLACE && cnt_reg == 8'h00 && duration_reg == 8'h00 && !trail_edge)
            |=> (state_reg == ST_IDLE);
    endproperty
    a_zero_duration: assert property (p_zero_duration) else $error("Zero duration opened a window");

    property p_restart_drop;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (trail_edge && !ext_sel_reg) |=> !clamp_active_out;
    endproperty
    a_restart_drop: assert property (p_restart_drop) else $error("Window stayed open across restart");

endmodule : clamp_timing_gen

// [tb/video_source.sv]
// Behavioural video source: hsync pulses, clamp strobe and converter codes.
// Assumes the bench asks for lines and sets the analog levels per channel.
module video_source
    import clamp_timing_pkg::*;
(
    // Clock and reset
    input  wire logic                         core_clk_in,
    input  wire logic                         rstn_in,
    // Bench control
    input  wire logic                         line_in,
    input  wire logic [7:0]                   width_in,
    input  wire logic                         strobe_lvl_in,
    input  wire logic [NUM_CHANNELS-1:0][7:0] level_in,
    input  wire logic [NUM_CHANNELS-1:0][6:0] offset_in,
    // To the generator
    output logic                              hsync_out,
    output logic                              strobe_out,
    output logic      [NUM_CHANNELS-1:0][7:0] code_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] hs_cnt_reg;

    // Clipped like a real converter, so a large trim cannot wrap
    function automatic logic [7:0] conv(input logic [7:0] lvl, input logic [6:0] off);
        int s;
        s = int'(lvl) + int'(signed'(off));
        return (s < 0) ? 8'h00 : (s > 255) ? 8'hff : 8'(s);
    endfunction : conv

    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            hs_cnt_reg <= 8'h00;
        else if (line_in)
            hs_cnt_reg <= width_in;
        else if (hs_cnt_reg != 8'h00)
            hs_cnt_reg <= hs_cnt_reg - 8'h01;
    end

    always_ff @(posedge core_clk_in)
    begin
        strobe_out <= strobe_lvl_in;
    end

    assign hsync_out = (hs_cnt_reg != 8'h00);

    always_comb
    begin
        for (int i = 0; i < NUM_CHANNELS; i++)
            code_out[i] = conv(level_in[i], offset_in[i]);
    end
endmodule : video_source

// [tb/tb.sv]
// Self-checking bench for the clamp timing generator.
// Assumes the video source model and an AHB-Lite master built from tasks.
module tb;
    import clamp_timing_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic                         core_clk_in;
    logic                         rstn_in;
    logic                         hsel;
    logic [31:0]                  haddr;
    logic [1:0]                   htrans;
    logic                         hwrite;
    logic [31:0]                  hwdata;
    logic [31:0]                  hrdata_out;
    logic                         hreadyout_out;
    logic                         hresp_out;
    logic                         hsync;
    logic                         strobe;
    logic [NUM_CHANNELS-1:0][7:0] code;
    logic [NUM_CHANNELS-1:0][6:0] offset_out;
    logic                         clamp_active_out;
    logic                         line;
    logic                         strobe_lvl;
    logic [NUM_CHANNELS-1:0][7:0] level;
    int                           err_count;
    int                           cmp_count;
    int                           cycles;

    clamp_timing_gen dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hreadyout_out),
        .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .hsync_in(hsync),
        .clamp_strobe_in(strobe), .code_in(code), .offset_out(offset_out), .clamp_active_out(clamp_active_out));

    video_source src (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .line_in(line), .width_in(8'h03),
        .strobe_lvl_in(strobe_lvl), .level_in(level), .offset_in(offset_out), .hsync_out(hsync),
        .strobe_out(strobe), .code_out(code));

    always #4 core_clk_in = ~core_clk_in;

    task automatic close_out();
        if (err_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk_in);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge core_clk_in); while (hreadyout_out !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge core_clk_in); while (hreadyout_out !== 1'b1);
        rd = hrdata_out;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        bus(1'b1, a, d, v);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, v);
        chk(v, exp);
    endtask : rd_chk

    task automatic send_line();
        @(posedge core_clk_in);
        line <= 1'b1;
        @(posedge core_clk_in);
        line <= 1'b0;
    endtask : send_line

    task automatic wait_fall();
        logic prev;
        prev = hsync;
        do
        begin
            @(posedge core_clk_in);
            #1;
            if (prev === 1'b1 && hsync === 1'b0)
                break;
            prev = hsync;
        end
        while (1);
    endtask : wait_fall

    task automatic measure(input logic [7:0] p, input logic [7:0] d);
        int n;
        n = 0;
        wait_fall();
        while (clamp_active_out !== 1'b1)
        begin
            @(posedge core_clk_in);
            #1;
            n++;
        end
        chk(32'(n), 32'(p) + 32'h2);
        n = 0;
        while (clamp_active_out === 1'b1)
        begin
            n++;
            @(posedge core_clk_in);
            #1;
        end
        chk(32'(n), 32'(d));
    endtask : measure

    task automatic t_reset();
        chk({31'h0, clamp_active_out}, 32'h0);
        chk({31'h0, hresp_out}, 32'h0);
        rd_chk(CTRL_OFFSET, 32'h2);
        rd_chk(PLACEMENT_OFFSET, 32'h8);
        rd_chk(DURATION_OFFSET, 32'h14);
        rd_chk(STATUS_OFFSET, 32'h0);
        rd_chk(TRIM_OFFSET, 32'h003f3f3f);
        wr(8'h20, 32'hffffffff);
        rd_chk(8'h20, 32'h0);
    endtask : t_reset

    // Strobe held active throughout: any leak into the window shows as n = 0
    task automatic t_internal();
        logic [7:0] pl [3] = '{8'h08, 8'h00, 8'hff};
        logic [7:0] du [3] = '{8'h14, 8'h01, 8'hff};
        for (int i = 0; i < 3; i++)
        begin
            wr(PLACEMENT_OFFSET, {24'h0, pl[i]});
            wr(DURATION_OFFSET, {24'h0, du[i]});
            send_line();
            measure(pl[i], du[i]);
        end
    endtask : t_internal

    task automatic t_restart();
        wr(PLACEMENT_OFFSET, 32'h10);
        wr(DURATION_OFFSET, 32'h4);
        send_line();
        wait_fall();
        rd_chk(STATUS_OFFSET, 32'h2);
        repeat (5) @(posedge core_clk_in);
        send_line();
        measure(8'h10, 8'h04);
    endtask : t_restart

    task automatic t_external();
        for (int i = 0; i < 4; i++)
        begin
            wr(CTRL_OFFSET, {30'h0, i[1], 1'b1});
            @(posedge core_clk_in);
            strobe_lvl <= i[0];
            repeat (3) @(posedge core_clk_in);
            #1;
            chk({31'h0, clamp_active_out}, {31'h0, i[0] == i[1]});
            rd_chk(STATUS_OFFSET, {31'h0, i[0] == i[1]});
        end
        wr(CTRL_OFFSET, 32'h2);
    endtask : t_external

    // Long window so every lane settles, one of them on the trim floor
    task automatic t_trim();
        @(posedge core_clk_in);
        level <= {8'd70, 8'd10, 8'd0};
        wr(TRIM_OFFSET, 32'h003f3f3f);
        wr(PLACEMENT_OFFSET, 32'h8);
        wr(DURATION_OFFSET, 32'hc8);
        send_line();
        measure(8'h08, 8'hc8);
        @(posedge core_clk_in);
        level <= {8'h80, 8'h80, 8'h80};
        for (int k = 0; k < 2; k++)
        begin
            repeat (10) @(posedge core_clk_in);
            #1;
            chk({25'h0, offset_out[0]}, 32'h00);
            chk({25'h0, offset_out[1]}, 32'h76);
            chk({25'h0, offset_out[2]}, 32'h41);
        end
    endtask : t_trim

    always @(posedge core_clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            close_out();
        end
    end

    initial
    begin
        core_clk_in = 1'b0;
        rstn_in = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        line = 1'b0;
        strobe_lvl = 1'b1;
        level = '0;
        err_count = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (20) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        @(posedge core_clk_in);
        #1;
        t_reset();
        t_internal();
        t_restart();
        t_external();
        t_trim();
        close_out();
    end
endmodule : tb
